//--- cmwc_pkg.sv
package cmwc_pkg;

    // Transceiver mode field encodings; upper bit high in normal/rx-only
    localparam logic [1:0] CMWC_XCVR_OFF = 2'h0;
    localparam logic [1:0] CMWC_XCVR_WAKE = 2'h1;
    localparam logic [1:0] CMWC_XCVR_RXONLY = 2'h2;
    localparam logic [1:0] CMWC_XCVR_NORMAL = 2'h3;
    localparam int CMWC_UV_SUPERVISE_BIT = 1;

    // Chip operating modes
    typedef enum logic [2:0]
    {
        CMWC_CHIP_NORMAL,
        CMWC_CHIP_STOP,
        CMWC_CHIP_SLEEP,
        CMWC_CHIP_RESTART,
        CMWC_CHIP_FAILSAFE
    } cmwc_chip_t;

    // Termination choices
    typedef enum logic [1:0]
    {
        CMWC_TERM_FLOAT,
        CMWC_TERM_HALF,
        CMWC_TERM_GND,
        CMWC_TERM_2V5
    } cmwc_term_t;

    // Mode change request from the SPI side
    typedef struct packed
    {
        logic valid;
        logic [1:0] mode;
    } cmwc_mode_req_t;

    // Fault and status flags
    typedef struct packed
    {
        logic xcvr_fault;
        logic supply_low;
        logic bus_wake;
    } cmwc_flags_t;

    // Times in ns and derived cycle counts at 125 MHz
    localparam int CMWC_CLK_NS = 8;
    localparam int CMWC_WAKE_MIN_NS = 500;
    localparam int CMWC_WAKE_MAX_NS = 1_000_000;
    localparam int CMWC_SILENCE_NS = 1_000_000;
    localparam int CMWC_TX_TO_NS = 2_000_000;
    localparam int CMWC_BUS_TO_NS = 4_000_000;
    localparam int CMWC_WAKE_MIN_CYC =
        (CMWC_WAKE_MIN_NS + CMWC_CLK_NS - 1) / CMWC_CLK_NS;
    localparam int CMWC_WAKE_MAX_CYC = CMWC_WAKE_MAX_NS / CMWC_CLK_NS;
    localparam int CMWC_SILENCE_CYC =
        (CMWC_SILENCE_NS + CMWC_CLK_NS - 1) / CMWC_CLK_NS;
    localparam int CMWC_TX_TO_CYC =
        (CMWC_TX_TO_NS + CMWC_CLK_NS - 1) / CMWC_CLK_NS;
    localparam int CMWC_BUS_TO_CYC =
        (CMWC_BUS_TO_NS + CMWC_CLK_NS - 1) / CMWC_CLK_NS;
    localparam int CMWC_CNT_W = 20;

endpackage

//--- cmwc_timer.sv
`timescale 1ns/1ns
// Saturating phase counter: counts while i_run, clears otherwise
module cmwc_timer
    import cmwc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Control
    input wire logic i_run,
    input wire logic [CMWC_CNT_W-1:0] i_limit,
    // Status
    output logic [CMWC_CNT_W-1:0] o_count,
    output logic o_expired
);

    logic [CMWC_CNT_W-1:0] count_reg;

    // Saturate so a long phase never wraps back to a short one
    always_ff @(posedge i_clk)
    begin
        if (i_srst || !i_run)
            count_reg <= '0;
        else if (count_reg != {CMWC_CNT_W{1'b1}})
            count_reg <= count_reg + 1'b1;
    end

    assign o_count = count_reg;
    assign o_expired = i_run && (count_reg >= i_limit);

endmodule // cmwc_timer

//--- cmwc_xcvr_ctrl.sv
`timescale 1ns/1ns
// Summary of operation
// R1 - Receive-only: driver off, receiver still forwards the bus level
// R2 - Receive-only request taken only in chip Normal or Stop
// R3 - Wake-capable set in Stop/Sleep/Restart/Normal; forced in Fail-Safe
// R4 - Wake in wake-capable mode holds receive output low until mode change
// R5 - Wake pattern: dominant, recessive, dominant, each between min and max
// R6 - Mode field keeps reading wake-capable after a wake
// R7 - Rearm after non-wake mode then wake-capable written again
// R8 - Rearm automatically on chip entry to Stop, Sleep or Fail-Safe
// R9 - Wake in Stop/Normal raises interrupt and sets bus wake status
// R10 - Stay in Stop after wake; controller commands Normal
// R11 - Wake in Stop enables watchdog if watchdog-on-bus-wake set
// R12 - Wake in Sleep goes Restart then Normal with no interrupt
// R13 - Chip mode after wake: Normal/Stop keep, others go Restart
// R14 - Termination follows transceiver mode, supply and wake state
// R15 - Ground termination waits for bus silence time after entry
// R16 - Transmit dominant timeout forces recessive and sets fault flag
// R17 - Transmitter resumes once the dominant transmit input clears
// R18 - Bus dominant beyond timeout sets fault flag, config unchanged
// R19 - Bus clamping time longer than transmit timeout
// R20 - Supply low sets flag and disables transmitter
// R21 - Supply recovery re-enables transmission by itself
// R22 - Supply supervision only while upper mode bit is one
// R23 - Off mode after reset; bus wake ignored in off mode
// R24 - Wake, transmit and bus timeouts use parameterised counters
module cmwc_xcvr_ctrl
    import cmwc_pkg::*;
#(
    parameter logic [CMWC_CNT_W-1:0] P_WAKE_MIN =
        CMWC_CNT_W'(CMWC_WAKE_MIN_CYC),
    parameter logic [CMWC_CNT_W-1:0] P_WAKE_MAX =
        CMWC_CNT_W'(CMWC_WAKE_MAX_CYC),
    parameter logic [CMWC_CNT_W-1:0] P_SILENCE = CMWC_CNT_W'(CMWC_SILENCE_CYC),
    parameter logic [CMWC_CNT_W-1:0] P_TX_TO = CMWC_CNT_W'(CMWC_TX_TO_CYC),
    parameter logic [CMWC_CNT_W-1:0] P_BUS_TO = CMWC_CNT_W'(CMWC_BUS_TO_CYC)
)
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_SRST,
    // Mode control from SPI side
    input wire cmwc_mode_req_t I_MODE_REQ,
    input wire logic I_CHIP_NORMAL_REQ,
    input wire logic I_WATCHDOG_ON_BUS_WAKE,
    input wire logic I_WATCHDOG_EN,
    input wire logic I_FLAG_CLEAR,
    // Pins and analog status
    input wire logic I_BUS_TRANSMIT_IN,
    input wire logic I_BUS_LEVEL,
    input wire logic I_TRANSCEIVER_SUPPLY_LOW,
    // Transceiver outputs
    output logic O_BUS_RECEIVE_OUT,
    output logic O_DRIVER_EN,
    output logic O_DRIVER_DOMINANT,
    output cmwc_term_t O_TERMINATION,
    // Status outputs
    output logic [1:0] O_XCVR_MODE,
    output cmwc_chip_t O_CHIP_MODE,
    output cmwc_flags_t O_FLAGS,
    output logic O_INTERRUPT_LOW_OUT,
    output logic O_WATCHDOG_FORCE_EN
);

    // Wake pattern detector phases
    typedef enum logic [2:0]
    {
        CMWC_WP_IDLE,
        CMWC_WP_DOM1,
        CMWC_WP_REC,
        CMWC_WP_DOM2,
        CMWC_WP_DONE
    } cmwc_wp_t;

    logic [1:0] mode_reg;
    cmwc_chip_t chip_reg;
    cmwc_chip_t chip_prev_reg;
    cmwc_wp_t wp_reg;
    cmwc_wp_t wp_next;
    logic woken_reg;
    logic armed_reg;
    logic silent_done_reg;
    logic tx_block_reg;
    logic xcvr_fault_reg;
    logic supply_low_reg;
    logic bus_wake_reg;
    logic int_low_reg;
    logic wd_force_reg;
    logic rx_reg;
    logic drv_en_reg;
    logic drv_dom_reg;
    cmwc_term_t term_reg;
    logic phase_restart;
    logic phase_ok;
    logic phase_long;
    logic wake_event;
    logic mode_write;
    logic req_ok;
    logic enter_rearm_chip;
    logic uv_active;
    logic tx_to;
    logic bus_to;
    logic silence_done;
    logic [CMWC_CNT_W-1:0] phase_cnt;

    // Phase counter restarts on every bus level change
    logic bus_prev_reg;
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
            bus_prev_reg <= 1'b1;
        else
            bus_prev_reg <= I_BUS_LEVEL;
    end
    assign phase_restart = (bus_prev_reg != I_BUS_LEVEL);

    cmwc_timer u_phase
    (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_run(!phase_restart && mode_reg == CMWC_XCVR_WAKE),
        .i_limit(P_WAKE_MIN),
        .o_count(phase_cnt), // see R24
        .o_expired()
    );
    // Phase closing length check, in cycles of the old level
    assign phase_ok = (phase_cnt >= P_WAKE_MIN) && (phase_cnt < P_WAKE_MAX);
    assign phase_long = (phase_cnt >= P_WAKE_MAX);

    // Transmit dominant timeout counter
    cmwc_timer u_tx_to
    (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_run(mode_reg == CMWC_XCVR_NORMAL && !I_BUS_TRANSMIT_IN),
        .i_limit(P_TX_TO),
        .o_count(),
        .o_expired(tx_to) // see R16 see R24
    );

    // Bus clamping counter; limit must exceed the transmit timeout
    cmwc_timer u_bus_to
    (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_run(mode_reg[CMWC_UV_SUPERVISE_BIT] && !I_BUS_LEVEL),
        .i_limit(P_BUS_TO), // see R19
        .o_count(),
        .o_expired(bus_to) // see R18 see R24
    );

    // Bus silence before ground termination
    cmwc_timer u_silence
    (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_run(mode_reg == CMWC_XCVR_WAKE && I_BUS_LEVEL),
        .i_limit(P_SILENCE),
        .o_count(),
        .o_expired(silence_done)
    );

    // Mode request gating by chip mode
    always_comb
    begin
        unique case (I_MODE_REQ.mode)
            CMWC_XCVR_RXONLY:
                req_ok = chip_reg == CMWC_CHIP_NORMAL
                    || chip_reg == CMWC_CHIP_STOP; // see R2
            CMWC_XCVR_WAKE:
                req_ok = chip_reg != CMWC_CHIP_FAILSAFE; // see R3
            CMWC_XCVR_NORMAL:
                req_ok = chip_reg == CMWC_CHIP_NORMAL;
            CMWC_XCVR_OFF:
                req_ok = 1'b1;
        endcase
    end
    assign mode_write = I_MODE_REQ.valid && req_ok;
    assign enter_rearm_chip = (chip_reg != chip_prev_reg)
        && (chip_reg == CMWC_CHIP_STOP || chip_reg == CMWC_CHIP_SLEEP
        || chip_reg == CMWC_CHIP_FAILSAFE);

    // Transceiver mode field; keeps wake-capable after a wake
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
            mode_reg <= CMWC_XCVR_OFF; // see R23
        else if (chip_reg == CMWC_CHIP_FAILSAFE)
            mode_reg <= CMWC_XCVR_WAKE; // see R3
        else if (mode_write)
            mode_reg <= I_MODE_REQ.mode; // see R6
    end

    // Wake pattern recogniser
    always_comb
    begin
        wp_next = wp_reg;
        unique case (wp_reg)
            CMWC_WP_IDLE:
                if (phase_restart && !I_BUS_LEVEL)
                    wp_next = CMWC_WP_DOM1;
            CMWC_WP_DOM1:
                if (phase_restart)
                    wp_next = phase_ok ? CMWC_WP_REC : CMWC_WP_IDLE; // see R5
            CMWC_WP_REC:
                if (phase_restart)
                    wp_next = phase_ok ? CMWC_WP_DOM2 : CMWC_WP_IDLE;
                else if (phase_long)
                    wp_next = CMWC_WP_IDLE;
            CMWC_WP_DOM2:
                if (phase_restart)
                    wp_next = phase_ok ? CMWC_WP_DONE : CMWC_WP_IDLE;
            CMWC_WP_DONE:
                wp_next = CMWC_WP_IDLE;
            default:
                wp_next = CMWC_WP_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST || mode_reg != CMWC_XCVR_WAKE || !armed_reg)
            wp_reg <= CMWC_WP_IDLE; // see R23
        else
            wp_reg <= wp_next;
    end
    assign wake_event = (wp_reg == CMWC_WP_DONE);

    // Arming: cleared by a wake, set by leaving wake mode or chip entry to Stop, Sleep or Fail-Safe
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
            armed_reg <= 1'b1;
        else if (enter_rearm_chip)
            armed_reg <= 1'b1; // see R8
        else if (wake_event)
            armed_reg <= 1'b0;
        else if (mode_reg != CMWC_XCVR_WAKE)
            armed_reg <= 1'b1; // see R7
    end

    // Woken state lasts until the transceiver mode changes or the chip enters Stop, Sleep or Fail-Safe
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
            woken_reg <= 1'b0;
        else if (wake_event)
            woken_reg <= 1'b1; // see R4
        else if (mode_reg != CMWC_XCVR_WAKE || enter_rearm_chip)
            woken_reg <= 1'b0;
    end

    // Chip mode tracking and wake actions
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            chip_reg <= CMWC_CHIP_NORMAL;
            chip_prev_reg <= CMWC_CHIP_NORMAL;
        end
        else
        begin
            chip_prev_reg <= chip_reg;
            if (wake_event && chip_reg != CMWC_CHIP_NORMAL
                && chip_reg != CMWC_CHIP_STOP)
                chip_reg <= CMWC_CHIP_RESTART; // see R12 see R13
            else if (chip_reg == CMWC_CHIP_RESTART)
                chip_reg <= CMWC_CHIP_NORMAL; // see R12
            else if (I_CHIP_NORMAL_REQ)
                chip_reg <= CMWC_CHIP_NORMAL; // see R10
        end
    end

    // Interrupt and status only for Normal/Stop wakes; set beats clear
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            bus_wake_reg <= 1'b0;
            int_low_reg <= 1'b1;
        end
        else if (wake_event && (chip_reg == CMWC_CHIP_NORMAL
            || chip_reg == CMWC_CHIP_STOP))
        begin
            bus_wake_reg <= 1'b1; // see R9
            int_low_reg <= 1'b0; // see R9
        end
        else if (I_FLAG_CLEAR)
        begin
            bus_wake_reg <= 1'b0;
            int_low_reg <= 1'b1;
        end
    end

    // Watchdog forced on by a Stop-mode wake
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
            wd_force_reg <= 1'b0;
        else if (wake_event && chip_reg == CMWC_CHIP_STOP
            && I_WATCHDOG_ON_BUS_WAKE && !I_WATCHDOG_EN)
            wd_force_reg <= 1'b1; // see R11
        else if (I_WATCHDOG_EN)
            wd_force_reg <= 1'b0;
    end

    // Transmit timeout hold, released once input goes recessive
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
            tx_block_reg <= 1'b0;
        else if (tx_to)
            tx_block_reg <= 1'b1; // see R16
        else if (I_BUS_TRANSMIT_IN)
            tx_block_reg <= 1'b0; // see R17
    end

    // Fault flags; set wins over clear, mode bits untouched
    assign uv_active = mode_reg[CMWC_UV_SUPERVISE_BIT]; // see R22
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            xcvr_fault_reg <= 1'b0;
            supply_low_reg <= 1'b0;
        end
        else
        begin
            if (tx_to || bus_to)
                xcvr_fault_reg <= 1'b1; // see R16 see R18
            else if (I_FLAG_CLEAR)
                xcvr_fault_reg <= 1'b0;
            if (uv_active && I_TRANSCEIVER_SUPPLY_LOW)
                supply_low_reg <= 1'b1; // see R20
            else if (I_FLAG_CLEAR)
                supply_low_reg <= 1'b0;
        end
    end

    // Silence latch before ground termination
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST || mode_reg != CMWC_XCVR_WAKE)
            silent_done_reg <= 1'b0;
        else if (silence_done)
            silent_done_reg <= 1'b1; // see R15
    end

    // Driver and receive output; receive output forwarded in normal/rx-only, low once woken, high otherwise
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            drv_en_reg <= 1'b0;
            drv_dom_reg <= 1'b0;
            rx_reg <= 1'b1;
        end
        else
        begin
            drv_en_reg <= (mode_reg == CMWC_XCVR_NORMAL) && !tx_block_reg
                && !tx_to
                && !(uv_active && I_TRANSCEIVER_SUPPLY_LOW); // see R1 see R21
            drv_dom_reg <= !I_BUS_TRANSMIT_IN;
            if (mode_reg == CMWC_XCVR_WAKE)
                rx_reg <= !woken_reg && !wake_event; // see R4
            else if (uv_active)
                rx_reg <= I_BUS_LEVEL; // see R1
            else
                rx_reg <= 1'b1;
        end
    end

    // Termination selection by mode
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
            term_reg <= CMWC_TERM_FLOAT;
        else
        begin
            unique case (mode_reg)
                CMWC_XCVR_NORMAL:
                    term_reg <= CMWC_TERM_HALF;
                CMWC_XCVR_RXONLY:
                    term_reg <= I_TRANSCEIVER_SUPPLY_LOW
                        ? CMWC_TERM_2V5 : CMWC_TERM_HALF; // see R14
                CMWC_XCVR_WAKE:
                    term_reg <= woken_reg ? CMWC_TERM_2V5
                        : (silent_done_reg ? CMWC_TERM_GND
                        : CMWC_TERM_FLOAT); // see R14 see R15
                CMWC_XCVR_OFF:
                    term_reg <= CMWC_TERM_FLOAT;
            endcase
        end
    end

    // Output wiring
    assign O_BUS_RECEIVE_OUT = rx_reg;
    assign O_DRIVER_EN = drv_en_reg;
    assign O_DRIVER_DOMINANT = drv_dom_reg && drv_en_reg;
    assign O_TERMINATION = term_reg;
    assign O_XCVR_MODE = mode_reg;
    assign O_CHIP_MODE = chip_reg;
    assign O_FLAGS = '{xcvr_fault: xcvr_fault_reg,
        supply_low: supply_low_reg, bus_wake: bus_wake_reg};
    assign O_INTERRUPT_LOW_OUT = int_low_reg;
    assign O_WATCHDOG_FORCE_EN = wd_force_reg;

endmodule // cmwc_xcvr_ctrl

//--- cmwc_props.sv
`timescale 1ns/1ns
// Port-level checker for the transceiver mode and wake control
module cmwc_props
    import cmwc_pkg::*;
(
    // Clock, reset and controls
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire cmwc_mode_req_t I_MODE_REQ,
    input wire logic I_CHIP_NORMAL_REQ,
    input wire logic I_WATCHDOG_ON_BUS_WAKE,
    input wire logic I_WATCHDOG_EN,
    input wire logic I_FLAG_CLEAR,
    input wire logic I_BUS_TRANSMIT_IN,
    input wire logic I_BUS_LEVEL,
    input wire logic I_TRANSCEIVER_SUPPLY_LOW,
    // Watched outputs
    input wire logic O_BUS_RECEIVE_OUT,
    input wire logic O_DRIVER_EN,
    input wire logic O_DRIVER_DOMINANT,
    input wire cmwc_term_t O_TERMINATION,
    input wire logic [1:0] O_XCVR_MODE,
    input wire cmwc_chip_t O_CHIP_MODE,
    input wire cmwc_flags_t O_FLAGS,
    input wire logic O_INTERRUPT_LOW_OUT,
    input wire logic O_WATCHDOG_FORCE_EN
);
    logic [CMWC_CNT_W-1:0] txc_reg, bsc_reg, wkc_reg;
    logic tx_run, bs_run, wk_run;
    // Run lengths; limits are not visible at the ports, so floors only
    assign tx_run = O_XCVR_MODE == CMWC_XCVR_NORMAL && !I_BUS_TRANSMIT_IN;
    assign bs_run = O_XCVR_MODE[1] && !I_BUS_LEVEL;
    assign wk_run = O_XCVR_MODE == CMWC_XCVR_WAKE;
    always_ff @(posedge I_CLK)
    begin
        txc_reg <= (tx_run && !I_SRST) ? txc_reg + 1'b1 : '0;
        bsc_reg <= (bs_run && !I_SRST) ? bsc_reg + 1'b1 : '0;
        wkc_reg <= (wk_run && !I_SRST) ? wkc_reg + 1'b1 : '0;
    end
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_SRST);
    property p_reset_off;
        $fell(I_SRST) |-> O_XCVR_MODE == CMWC_XCVR_OFF && O_BUS_RECEIVE_OUT
            && O_TERMINATION == CMWC_TERM_FLOAT && O_INTERRUPT_LOW_OUT;
    endproperty
    a_reset_off: assert property (p_reset_off)
        else $error("reset state wrong");
    property p_rxonly;
        O_XCVR_MODE == CMWC_XCVR_RXONLY && $past(O_XCVR_MODE, 2) == 2'h2
            |-> !O_DRIVER_EN && O_BUS_RECEIVE_OUT == $past(I_BUS_LEVEL);
    endproperty
    a_rxonly: assert property (p_rxonly)
        else $error("rx-only path wrong");
    property p_wake_hold;
        wk_run && O_FLAGS.bus_wake && !O_BUS_RECEIVE_OUT && !I_MODE_REQ.valid
            |=> !O_BUS_RECEIVE_OUT && O_XCVR_MODE == CMWC_XCVR_WAKE;
    endproperty
    a_wake_hold: assert property (p_wake_hold)
        else $error("woken state not held");
    property p_wake_int;
        $rose(O_FLAGS.bus_wake) && O_CHIP_MODE == CMWC_CHIP_NORMAL
            |-> !O_INTERRUPT_LOW_OUT && !O_BUS_RECEIVE_OUT;
    endproperty
    a_wake_int: assert property (p_wake_int)
        else $error("wake signalling wrong");
    property p_tx_to;
        $past(tx_run) && tx_run && $past(I_BUS_LEVEL)
            && $rose(O_FLAGS.xcvr_fault)
            |-> !O_DRIVER_EN && !O_DRIVER_DOMINANT && txc_reg > 20'h0_0008;
    endproperty
    a_tx_to: assert property (p_tx_to)
        else $error("transmit timeout missed");
    property p_bus_to;
        $past(bs_run) && !$past(tx_run) && $rose(O_FLAGS.xcvr_fault)
            |-> $stable(O_XCVR_MODE) && bsc_reg > 20'h0_0008;
    endproperty
    a_bus_to: assert property (p_bus_to)
        else $error("bus clamp missed");
    property p_uv;
        I_TRANSCEIVER_SUPPLY_LOW && O_XCVR_MODE[1]
            |-> ##[1:2] O_FLAGS.supply_low;
    endproperty
    a_uv: assert property (p_uv)
        else $error("supply low missed");
    property p_silence;
        wk_run && wkc_reg < 20'h0_0004
            |-> O_TERMINATION != CMWC_TERM_GND;
    endproperty
    a_silence: assert property (p_silence)
        else $error("ground early");
    c_wake: cover property ($rose(O_FLAGS.bus_wake));
    c_fault: cover property ($rose(O_FLAGS.xcvr_fault));
    c_uv: cover property ($rose(O_FLAGS.supply_low));
endmodule // cmwc_props

bind cmwc_xcvr_ctrl cmwc_props cmwc_props_i (
    .I_CLK, .I_SRST, .I_MODE_REQ, .I_CHIP_NORMAL_REQ,
    .I_WATCHDOG_ON_BUS_WAKE, .I_WATCHDOG_EN, .I_FLAG_CLEAR,
    .I_BUS_TRANSMIT_IN, .I_BUS_LEVEL, .I_TRANSCEIVER_SUPPLY_LOW,
    .O_BUS_RECEIVE_OUT, .O_DRIVER_EN, .O_DRIVER_DOMINANT, .O_TERMINATION,
    .O_XCVR_MODE, .O_CHIP_MODE, .O_FLAGS, .O_INTERRUPT_LOW_OUT,
    .O_WATCHDOG_FORCE_EN
);

//--- cmwc_bus_peer.sv
`timescale 1ns/1ns
// Remote bus node; recessive (high) when silent, as the bus idles
module cmwc_bus_peer
(
    // Clock
    input wire logic i_clk,
    // Bus level, 0 is dominant
    output logic o_bus
);
    initial
    begin
        o_bus = 1'b1;
    end
    // Dominant, recessive, dominant, n cycles each, then idle
    task automatic pattern(input int n);
        for (int p = 0; p < 3; p++)
        begin
            o_bus = (p == 1);
            repeat (n) @(posedge i_clk);
            #1;
        end
        o_bus = 1'b1;
    endtask
endmodule // cmwc_bus_peer

//--- tb_can_transceiver_mode_wake_control.sv
`timescale 1ns/1ns
module tb_can_transceiver_mode_wake_control;
    import cmwc_pkg::*;
    typedef struct {int id; logic [3:0] v;} cmwc_note_t;
    cmwc_note_t q[$];
    string nm[9] = '{"rx", "drv_en", "term", "mode", "int_n", "flags",
        "chip", "drv_dom", "wd_force"};
    logic [3:0] rst_v[9] = '{4'h1, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0,
        4'h0, 4'h0};
    int bad_count = 0;
    int samples_checked = 0;
    int n;
    logic clk = 1'b0, srst = 1'b1, tx = 1'b1, uv = 1'b0, fclr = 1'b0;
    logic wdb = 1'b0, cnr = 1'b0, bus_tb = 1'b1, wden = 1'b0;
    logic pbus, rx, den, ddom, interrupt_low_out, wdf;
    logic [1:0] xmode;
    cmwc_mode_req_t req = '0;
    cmwc_term_t term;
    cmwc_chip_t chip;
    cmwc_flags_t flags;
    // Short counts keep the run brief
    cmwc_xcvr_ctrl #(.P_WAKE_MIN(20'h0_0004), .P_WAKE_MAX(20'h0_0028),
        .P_SILENCE(20'h0_0014), .P_TX_TO(20'h0_0032), .P_BUS_TO(20'h0_0064))
    cmwc_xcvr_ctrl_i (.I_CLK(clk), .I_SRST(srst), .I_MODE_REQ(req),
        .I_CHIP_NORMAL_REQ(cnr), .I_WATCHDOG_ON_BUS_WAKE(wdb),
        .I_WATCHDOG_EN(wden), .I_FLAG_CLEAR(fclr), .I_BUS_TRANSMIT_IN(tx),
        .I_BUS_LEVEL(bus_tb & pbus), .I_TRANSCEIVER_SUPPLY_LOW(uv),
        .O_BUS_RECEIVE_OUT(rx), .O_DRIVER_EN(den), .O_DRIVER_DOMINANT(ddom),
        .O_TERMINATION(term), .O_XCVR_MODE(xmode), .O_CHIP_MODE(chip),
        .O_FLAGS(flags), .O_INTERRUPT_LOW_OUT(interrupt_low_out),
        .O_WATCHDOG_FORCE_EN(wdf));
    cmwc_bus_peer cmwc_bus_peer_i (.i_clk(clk), .o_bus(pbus));
    initial
    begin
        forever #4 clk = ~clk;
    end
    function automatic logic [3:0] obs(input int id);
        case (id)
            0: return {3'h0, rx};
            1: return {3'h0, den};
            2: return {2'h0, term};
            3: return {2'h0, xmode};
            4: return {3'h0, interrupt_low_out};
            5: return {1'h0, flags};
            6: return {1'h0, chip};
            7: return {3'h0, ddom};
            default: return {3'h0, wdf};
        endcase
    endfunction
    task automatic check(input string s, input logic [3:0] seen,
        input logic [3:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("BAD %s expected %h seen %h", s, exp, seen);
            bad_count++;
        end
    endtask
    task automatic wrap_up;
        if (bad_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Inputs move 1 ns after the rising edge
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic note(input int id, input logic [3:0] v);
        q.push_back('{id, v});
    endtask
    task automatic mode(input logic [1:0] m);
        req = '{1'b1, m};
        cyc(1);
        req = '0;
        cyc(1);
    endtask
    task automatic clr;
        fclr = 1'b1;
        cyc(1);
        fclr = 0;
        cyc(1);
    endtask
    // Bounded wait for the wake indication
    task automatic wait_rx0;
        for (int k = 0; k < 20 && rx !== 1'b0; k++)
            cyc(1);
        if (rx !== 1'b0)
        begin
            $display("BAD rx_wait expected 0 seen %b", rx);
            bad_count++;
            wrap_up;
        end
        cyc(1);
    endtask
    // Notes are judged at the falling edge, when outputs have settled
    always @(negedge clk)
    begin
        while (q.size() > 0)
        begin
            check(nm[q[0].id], obs(q[0].id), q[0].v);
            void'(q.pop_front());
        end
    end
    initial
    begin
        void'($urandom(32'hda4f46d6));
        cyc(3);
        srst = 1'b0;
        foreach (rst_v[i])
            note(i, rst_v[i]);
        cmwc_bus_peer_i.pattern(10);
        cyc(3);
        note(5, 4'h0);
        // Normal, then rx-only: driver, termination, received level
        for (int m = 3; m >= 2; m--)
        begin
            mode(2'(m));
            note(1, {3'h0, m == 3});
            note(2, 4'(CMWC_TERM_HALF));
            repeat (6)
            begin
                bus_tb = 1'($urandom);
                cyc(1);
                note(0, {3'h0, bus_tb});
            end
        end
        // Clamped bus in rx-only; one recessive cycle clears random lows
        bus_tb = 1'b1;
        cyc(1);
        bus_tb = 1'b0;
        cyc(90);
        note(5, 4'h0);
        cyc(20);
        note(5, 4'h4);
        note(3, 4'h2);
        bus_tb = 1'b1;
        clr;
        // Supply low in rx-only, then normal, then recovery
        uv = 1'b1;
        cyc(3);
        note(5, 4'h2);
        note(2, 4'(CMWC_TERM_2V5));
        mode(2'h3);
        note(1, 4'h0);
        uv = 1'b0;
        cyc(3);
        note(1, 4'h1);
        clr;
        // Stuck dominant transmit input
        tx = 1'b0;
        cyc(45);
        note(5, 4'h0);
        note(7, 4'h1);
        cyc(10);
        note(5, 4'h4);
        note(1, 4'h0);
        note(7, 4'h0);
        note(3, 4'h3);
        tx = 1'b1;
        cyc(3);
        note(1, 4'h1);
        clr;
        // Supply low while unsupervised
        mode(2'h0);
        uv = 1'b1;
        cyc(3);
        note(5, 4'h0);
        uv = 1'b0;
        mode(2'h1);
        cyc(10);
        note(2, 4'(CMWC_TERM_FLOAT));
        cyc(12);
        note(2, 4'(CMWC_TERM_GND));
        // Phases too short and too long are no wake pattern
        foreach (rst_v[i])
            if (i < 2)
            begin
                cmwc_bus_peer_i.pattern(i == 0 ? 2 : 45);
                cyc(4);
                note(0, 4'h1);
            end
        wdb = 1'b1;
        wden = 1'($urandom);
        n = 6 + $urandom_range(24);
        cmwc_bus_peer_i.pattern(n);
        wait_rx0;
        note(4, 4'h0);
        note(5, 4'h1);
        note(3, 4'h1);
        note(6, 4'(CMWC_CHIP_NORMAL));
        note(8, 4'h0);
        cyc(3);
        note(2, 4'(CMWC_TERM_2V5));
        note(0, 4'h0);
        // Without a mode change a second pattern is not seen
        clr;
        cmwc_bus_peer_i.pattern(8);
        cyc(4);
        note(5, 4'h0);
        mode(2'h3);
        note(0, 4'h1);
        mode(2'h1);
        cmwc_bus_peer_i.pattern(8);
        wait_rx0;
        note(5, 4'h1);
        cnr = 1'b1;
        cyc(1);
        cnr = 1'b0;
        cyc(2);
        note(6, 4'(CMWC_CHIP_NORMAL));
        cyc(2);
        wrap_up;
    end
endmodule // tb_can_transceiver_mode_wake_control
